// ### src/scd_pkg.sv
// Constants and types shared by the system control and decode block
//
// Function
// - Watchdog starts on enable bit with period
// - Disable needs cleared enable then key B1h
// - Watchdog master also selects halt power mode
// - Wait states only inside inclusive nibble range
// - Wait range register resets to F0h
// - Low select when nibble at most low bound
// - Upper select above low, up to high
// - Select range low nibble resets to ones
// - Misc bit 4 bypasses clock divide-by-two unless external clock selected
// - Idle two stops only the system clock
// - Stop mode halts whole clock generator
// - Halt left on reset or accepted interrupt
// - Low request with enable accepted, next cycle
// - Stopped clock restarts on reset or interrupt
// - Run mode keeps clock, services next cycle
// - Dummy cycle then fetch from 0000H
// - Request strobe on address, write on data
// - Zero to three waits plus opcode extra
// - Control registers through index/value ports
package scd_pkg;

    // ==================================================================
    // I/O addresses
    localparam logic [7:0] WD_MASTER_ADDR = 8'hF0;
    localparam logic [7:0] WD_COMMAND_ADDR = 8'hF1;
    localparam logic [7:0] CTRL_INDEX_ADDR = 8'hEE;
    localparam logic [7:0] CTRL_VALUE_ADDR = 8'hEF;

    // ==================================================================
    // Indirect register indices
    localparam logic [7:0] WAIT_CTRL_IDX = 8'h00;
    localparam logic [7:0] WAIT_RANGE_IDX = 8'h01;
    localparam logic [7:0] SELECT_RANGE_IDX = 8'h02;
    localparam logic [7:0] MISC_OPTIONS_IDX = 8'h03;

    // ==================================================================
    // Field positions
    localparam int WD_ENABLE_BIT = 7;
    localparam int WD_PERIOD_LSB = 5;
    localparam int HALT_MODE_LSB = 3;
    localparam int MISC_DIV_ONE_BIT = 4;
    localparam int MISC_UPPER_EN_BIT = 1;
    localparam int MISC_LOW_EN_BIT = 0;
    localparam int WAIT_OPC_EXTRA_BIT = 2;
    localparam int WAIT_MEM_LSB = 0;

    // ==================================================================
    // Values and reset values
    localparam logic [7:0] WD_DISABLE_KEY = 8'hB1;
    localparam logic [7:0] MISC_RSVD_MASK = 8'h1F;
    localparam logic [7:0] WD_MASTER_RST = 8'h00;
    localparam logic [7:0] WAIT_CTRL_RST = 8'h00;
    localparam logic [7:0] WAIT_RANGE_RST = 8'hF0;
    localparam logic [7:0] SELECT_RANGE_RST = 8'h0F;
    localparam logic [7:0] MISC_OPTIONS_RST = 8'h01;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;

    // ==================================================================
    // Timing counts in system clock cycles
    localparam int RESET_MIN_CYC = 3;
    localparam int DUMMY_MIN_CYC = 2;

    // ==================================================================
    // Types
    typedef enum logic [1:0] {
        HM_IDLE_ONE_MODE = 2'b00,
        HM_IDLE_TWO_MODE = 2'b01,
        HM_STOP = 2'b10,
        HM_RUN = 2'b11
    } scd_halt_mode_t;

    typedef enum logic [2:0] {
        PS_ACTIVE = 3'b000,
        PS_HALTED = 3'b001,
        PS_IDLE_ONE_MODE = 3'b010,
        PS_IDLE_TWO_MODE = 3'b011,
        PS_STOP = 3'b100
    } scd_pwr_state_t;

    typedef enum logic [1:0] {
        RS_RUN = 2'b00,
        RS_HOLD = 2'b01,
        RS_DUMMY = 2'b10
    } scd_rst_state_t;

    typedef struct packed {
        logic mem_req;
        logic opcode_fetch;
        logic write;
        logic addr_stable;
        logic data_stable;
        logic [15:0] addr;
    } scd_mem_cycle_t;

    typedef struct packed {
        logic memory_request_strobe_n;
        logic wr_n;
        logic low_sel_n;
        logic upper_sel_n;
        logic wait_n;
    } scd_mem_strobe_t;

    typedef struct packed {
        logic sys_clk_en;
        logic timer_clk_en;
        logic wd_clk_en;
        logic clk_out_en;
    } scd_clk_gate_t;

endpackage

// ### src/scd_range_decode.sv
// Address nibble comparators for wait range and chip selects
`timescale 1ns/100ps
module scd_range_decode
    import scd_pkg::*;
(
    // Address
    input wire logic [3:0] addr_nib_i,
    // Boundaries
    input wire logic [7:0] wait_range_i,
    input wire logic [7:0] select_range_i,
    // Decoded hits
    output logic wait_hit_o,
    output logic low_hit_o,
    output logic upper_hit_o
);

    // Inclusive compare between a low and a high nibble
    function automatic logic in_range(input logic [3:0] v, input logic [3:0] lo, input logic [3:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // Range decode
    always_comb begin
        wait_hit_o = in_range(addr_nib_i, wait_range_i[3:0], wait_range_i[7:4]);
        low_hit_o = addr_nib_i <= select_range_i[3:0];
        upper_hit_o = (addr_nib_i > select_range_i[3:0]) && (addr_nib_i <= select_range_i[7:4]);
    end

endmodule // scd_range_decode

// ### src/scd_top.sv
// System control: watchdog keys, memory decode, wait states, power-down, reset timing
`timescale 1ns/100ps
module scd_top
    import scd_pkg::*;
#(
    parameter int RESET_MIN = RESET_MIN_CYC,
    parameter int DUMMY_MIN = DUMMY_MIN_CYC
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // I/O register port from the processor core
    input wire logic [7:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    output logic io_ack_o,
    // Memory cycle from the core and strobes out
    input wire scd_mem_cycle_t mem_cyc_i,
    output scd_mem_strobe_t mem_strb_o,
    // Halt and interrupt handshake
    input wire logic halt_t4_i,
    input wire logic reset_n_i,
    input wire logic nmi_n_i,
    input wire logic int_n_i,
    input wire logic iff_i,
    input wire logic ext_clk_i,
    output logic halt_release_o,
    output logic int_accept_o,
    output logic iff_set_o,
    output logic cpu_reset_o,
    output logic fetch_start_o,
    output logic [15:0] fetch_addr_o,
    // Clock control
    output scd_clk_gate_t clk_gate_o,
    output logic clk_div_one_o,
    // Watchdog control
    output logic wd_run_o,
    output logic [1:0] wd_period_o
);

    // Refuse counts that the 8-bit reset counter cannot hold
    if (RESET_MIN < 1 || RESET_MIN > 255 || DUMMY_MIN < 1 || DUMMY_MIN > 255) begin : g_bad_counts
        $error("scd_top: reset counts must lie in 1..255");
    end


    localparam logic [7:0] RESET_MIN_C = 8'(RESET_MIN);
    localparam logic [7:0] DUMMY_MIN_C = 8'(DUMMY_MIN);

    // ==================================================================
    // Register file
    logic [7:0] wd_master_r, wd_master_nxt;
    logic wd_run_r, wd_run_nxt;
    logic [7:0] index_r, index_nxt;
    logic [7:0] wait_ctrl_r, wait_ctrl_nxt;
    logic [7:0] wait_range_r, wait_range_nxt;
    logic [7:0] select_range_r, select_range_nxt;
    logic [7:0] misc_r, misc_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic ack_r, ack_nxt;
    logic wr_master, wr_command, wr_index, wr_value;

    // Write decodes
    always_comb begin
        wr_master = io_wr_i && (io_addr_i == WD_MASTER_ADDR);
        wr_command = io_wr_i && (io_addr_i == WD_COMMAND_ADDR);
        wr_index = io_wr_i && (io_addr_i == CTRL_INDEX_ADDR);
        wr_value = io_wr_i && (io_addr_i == CTRL_VALUE_ADDR);
    end

    // Next register values and read data
    always_comb begin
        wd_master_nxt = wd_master_r;
        wd_run_nxt = wd_run_r;
        index_nxt = index_r;
        wait_ctrl_nxt = wait_ctrl_r;
        wait_range_nxt = wait_range_r;
        select_range_nxt = select_range_r;
        misc_nxt = misc_r;
        rdata_nxt = rdata_r;
        ack_nxt = io_wr_i || io_rd_i;
        if (wr_master) begin
            wd_master_nxt = io_wdata_i;
            if (io_wdata_i[WD_ENABLE_BIT]) begin
                wd_run_nxt = 1'b1;
            end
        end
        if (wr_command && io_wdata_i == WD_DISABLE_KEY && !wd_master_r[WD_ENABLE_BIT]) begin
            wd_run_nxt = 1'b0;
        end
        if (wr_index) begin
            index_nxt = io_wdata_i;
        end
        if (wr_value) begin
            unique case (index_r)
                WAIT_CTRL_IDX: wait_ctrl_nxt = io_wdata_i;
                WAIT_RANGE_IDX: wait_range_nxt = io_wdata_i;
                SELECT_RANGE_IDX: select_range_nxt = io_wdata_i;
                MISC_OPTIONS_IDX: misc_nxt = io_wdata_i & MISC_RSVD_MASK;
                default: misc_nxt = misc_r;
            endcase
        end
        if (io_rd_i) begin
            rdata_nxt = 8'h00;
            unique case (io_addr_i)
                WD_MASTER_ADDR: rdata_nxt = wd_master_r;
                CTRL_INDEX_ADDR: rdata_nxt = index_r;
                CTRL_VALUE_ADDR: begin
                    unique case (index_r)
                        WAIT_CTRL_IDX: rdata_nxt = wait_ctrl_r;
                        WAIT_RANGE_IDX: rdata_nxt = wait_range_r;
                        SELECT_RANGE_IDX: rdata_nxt = select_range_r;
                        MISC_OPTIONS_IDX: rdata_nxt = misc_r;
                        default: rdata_nxt = 8'h00;
                    endcase
                end
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // Register storage
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wd_master_r <= WD_MASTER_RST;
            wd_run_r <= 1'b0;
            index_r <= 8'h00;
            wait_ctrl_r <= WAIT_CTRL_RST;
            wait_range_r <= WAIT_RANGE_RST;
            select_range_r <= SELECT_RANGE_RST;
            misc_r <= MISC_OPTIONS_RST;
            rdata_r <= 8'h00;
            ack_r <= 1'b0;
        end else begin
            wd_master_r <= wd_master_nxt;
            wd_run_r <= wd_run_nxt;
            index_r <= index_nxt;
            wait_ctrl_r <= wait_ctrl_nxt;
            wait_range_r <= wait_range_nxt;
            select_range_r <= select_range_nxt;
            misc_r <= misc_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
        end
    end

    assign io_rdata_o = rdata_r;
    assign io_ack_o = ack_r;
    assign wd_period_o = wd_master_r[WD_PERIOD_LSB +: 2];
    assign clk_div_one_o = misc_r[MISC_DIV_ONE_BIT] && !ext_clk_i;

    // ==================================================================
    // Memory decode, strobes and wait states
    logic wait_hit, low_hit, upper_hit;
    logic [2:0] wait_cnt_r, wait_cnt_nxt;
    logic mem_prev_r, mem_prev_nxt;
    scd_mem_strobe_t strb_r, strb_nxt;

    scd_range_decode u_range (
        .addr_nib_i(mem_cyc_i.addr[15:12]),
        .wait_range_i(wait_range_r),
        .select_range_i(select_range_r),
        .wait_hit_o(wait_hit),
        .low_hit_o(low_hit),
        .upper_hit_o(upper_hit)
    );

    // Strobe ordering, selects and wait count
    always_comb begin
        logic req_on;
        req_on = mem_cyc_i.mem_req && mem_cyc_i.addr_stable;
        mem_prev_nxt = mem_cyc_i.mem_req;
        wait_cnt_nxt = wait_cnt_r;
        strb_nxt.memory_request_strobe_n = !req_on;
        strb_nxt.wr_n = !(req_on && mem_cyc_i.write && mem_cyc_i.data_stable);
        strb_nxt.low_sel_n = !(req_on && low_hit && misc_r[MISC_LOW_EN_BIT]);
        strb_nxt.upper_sel_n = !(req_on && upper_hit && misc_r[MISC_UPPER_EN_BIT]);
        if (mem_cyc_i.mem_req && !mem_prev_r) begin
            wait_cnt_nxt = 3'd0;
            if (wait_hit) begin
                wait_cnt_nxt = {1'b0, wait_ctrl_r[WAIT_MEM_LSB +: 2]}
                    + {2'b00, mem_cyc_i.opcode_fetch && wait_ctrl_r[WAIT_OPC_EXTRA_BIT]};
            end
        end else if (wait_cnt_r != 3'd0) begin
            wait_cnt_nxt = wait_cnt_r - 3'd1;
        end
        strb_nxt.wait_n = (wait_cnt_nxt == 3'd0);
    end

    // Strobe registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_cnt_r <= 3'd0;
            mem_prev_r <= 1'b0;
            strb_r <= '{memory_request_strobe_n: 1'b1, wr_n: 1'b1, low_sel_n: 1'b1, upper_sel_n: 1'b1, wait_n: 1'b1};
        end else begin
            wait_cnt_r <= wait_cnt_nxt;
            mem_prev_r <= mem_prev_nxt;
            strb_r <= strb_nxt;
        end
    end

    assign mem_strb_o = strb_r;

    // ==================================================================
    // Halt power-down and release
    scd_pwr_state_t pwr_r, pwr_nxt;
    scd_halt_mode_t halt_mode;
    logic release_r, release_nxt;
    logic accept_r, accept_nxt;
    logic wake;

    assign halt_mode = scd_halt_mode_t'(wd_master_r[HALT_MODE_LSB +: 2]);

    // Power state and halt release
    always_comb begin
        logic int_ok;
        int_ok = !nmi_n_i || (!int_n_i && iff_i);
        wake = !reset_n_i || !nmi_n_i || !int_n_i;
        pwr_nxt = pwr_r;
        release_nxt = 1'b0;
        accept_nxt = 1'b0;
        unique case (pwr_r)
            PS_ACTIVE: begin
                if (halt_t4_i) begin
                    unique case (halt_mode)
                        HM_IDLE_ONE_MODE: pwr_nxt = PS_IDLE_ONE_MODE;
                        HM_IDLE_TWO_MODE: pwr_nxt = PS_IDLE_TWO_MODE;
                        HM_STOP: pwr_nxt = PS_STOP;
                        HM_RUN: pwr_nxt = PS_HALTED;
                    endcase
                end
            end
            PS_HALTED: begin
                if (!reset_n_i) begin
                    pwr_nxt = PS_ACTIVE;
                    release_nxt = 1'b1;
                end else if (halt_t4_i && int_ok) begin
                    pwr_nxt = PS_ACTIVE;
                    release_nxt = 1'b1;
                    accept_nxt = 1'b1;
                end
            end
            PS_IDLE_ONE_MODE, PS_IDLE_TWO_MODE, PS_STOP: begin
                if (wake) begin
                    pwr_nxt = PS_HALTED;
                end
            end
            default: pwr_nxt = PS_ACTIVE;
        endcase
    end

    // Power state registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pwr_r <= PS_ACTIVE;
            release_r <= 1'b0;
            accept_r <= 1'b0;
        end else begin
            pwr_r <= pwr_nxt;
            release_r <= release_nxt;
            accept_r <= accept_nxt;
        end
    end

    // Clock gates per power state
    always_comb begin
        clk_gate_o.sys_clk_en = !(pwr_r inside {PS_IDLE_ONE_MODE, PS_IDLE_TWO_MODE, PS_STOP});
        clk_gate_o.timer_clk_en = !(pwr_r inside {PS_IDLE_ONE_MODE, PS_STOP});
        clk_gate_o.wd_clk_en = (pwr_r != PS_STOP);
        clk_gate_o.clk_out_en = (pwr_r != PS_STOP);
    end

    assign halt_release_o = release_r;
    assign int_accept_o = accept_r;
    assign iff_set_o = accept_r && !nmi_n_i ? 1'b0 : accept_r;
    assign wd_run_o = wd_run_r && (pwr_r != PS_STOP);

    // ==================================================================
    // Reset pin timing and dummy cycle
    scd_rst_state_t rs_r, rs_nxt;
    logic [7:0] rcnt_r, rcnt_nxt;
    logic creset_r, creset_nxt;
    logic fetch_r, fetch_nxt;

    // Reset hold counter and dummy cycle
    always_comb begin
        rs_nxt = rs_r;
        rcnt_nxt = rcnt_r;
        creset_nxt = creset_r;
        fetch_nxt = 1'b0;
        unique case (rs_r)
            RS_RUN: begin
                if (!reset_n_i) begin
                    rcnt_nxt = (rcnt_r == 8'hFF) ? rcnt_r : rcnt_r + 8'd1;
                    if (rcnt_nxt >= RESET_MIN_C) begin
                        rs_nxt = RS_HOLD;
                        creset_nxt = 1'b1;
                    end
                end else begin
                    rcnt_nxt = 8'd0;
                end
            end
            RS_HOLD: begin
                if (reset_n_i) begin
                    rs_nxt = RS_DUMMY;
                    rcnt_nxt = 8'd0;
                end
            end
            RS_DUMMY: begin
                rcnt_nxt = rcnt_r + 8'd1;
                if (!reset_n_i) begin
                    rs_nxt = RS_HOLD;
                end else if (rcnt_nxt >= DUMMY_MIN_C) begin
                    rs_nxt = RS_RUN;
                    rcnt_nxt = 8'd0;
                    creset_nxt = 1'b0;
                    fetch_nxt = 1'b1;
                end
            end
            default: rs_nxt = RS_RUN;
        endcase
    end

    // Reset timing registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rs_r <= RS_DUMMY;
            rcnt_r <= 8'd0;
            creset_r <= 1'b1;
            fetch_r <= 1'b0;
        end else begin
            rs_r <= rs_nxt;
            rcnt_r <= rcnt_nxt;
            creset_r <= creset_nxt;
            fetch_r <= fetch_nxt;
        end
    end

    assign cpu_reset_o = creset_r;
    assign fetch_start_o = fetch_r;
    assign fetch_addr_o = RESET_VECTOR;

endmodule // scd_top

// ### sim/scd_monitor.sv
// Concurrent checks on the system control block ports
`timescale 1ns/100ps
module scd_monitor
    import scd_pkg::*;
#(
    parameter int RESET_MIN = RESET_MIN_CYC,
    parameter int DUMMY_MIN = DUMMY_MIN_CYC
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Watched ports
    input wire logic [7:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    input wire logic io_ack_o,
    input wire scd_mem_cycle_t mem_cyc_i,
    input wire scd_mem_strobe_t mem_strb_o,
    input wire logic reset_n_i,
    input wire logic int_n_i,
    input wire logic ext_clk_i,
    input wire logic cpu_reset_o,
    input wire logic fetch_start_o,
    input wire logic [15:0] fetch_addr_o,
    input wire scd_clk_gate_t clk_gate_o,
    input wire logic clk_div_one_o,
    input wire logic wd_run_o,
    input wire logic [1:0] wd_period_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========
    // Steps of a memory cycle and of a pin reset
    sequence s_addr_up;
        mem_cyc_i.mem_req && mem_cyc_i.addr_stable;
    endsequence
    sequence s_pin_low;
        !reset_n_i [*3];
    endsequence
    // ==========
    // Properties
    a_memory_request_strobe_on_addr: assert property (s_addr_up |=> !mem_strb_o.memory_request_strobe_n)
        else $error("request strobe missed");
    a_wr_on_data: assert property (!mem_strb_o.wr_n |-> $past(mem_cyc_i.data_stable && mem_cyc_i.write))
        else $error("write strobe before data");
    a_sel_mem_only: assert property (!(mem_strb_o.low_sel_n && mem_strb_o.upper_sel_n) |-> $past(mem_cyc_i.mem_req))
        else $error("select outside memory cycle");
    a_sel_disjoint: assert property (mem_strb_o.low_sel_n || mem_strb_o.upper_sel_n)
        else $error("both selects active");
    a_wait_in_mem: assert property (!mem_strb_o.wait_n |-> $past(mem_cyc_i.mem_req))
        else $error("wait outside memory cycle");
    a_ack_follow: assert property ((io_wr_i || io_rd_i) |=> io_ack_o)
        else $error("missing ack");
    a_wd_start: assert property (io_wr_i && io_addr_i == WD_MASTER_ADDR && io_wdata_i[WD_ENABLE_BIT]
        |=> wd_run_o && wd_period_o == $past(io_wdata_i[6:5])) else $error("watchdog not started");
    a_wd_hold: assert property (io_wr_i && io_addr_i == WD_COMMAND_ADDR && io_wdata_i != WD_DISABLE_KEY
        && wd_run_o |=> wd_run_o) else $error("watchdog stopped without key");
    a_stop_all: assert property (!clk_gate_o.clk_out_en |-> !clk_gate_o.sys_clk_en && !wd_run_o)
        else $error("stop left clocks running");
    a_idle_timer: assert property (clk_gate_o.timer_clk_en && !clk_gate_o.sys_clk_en |-> clk_gate_o.clk_out_en)
        else $error("idle two stopped clock output");
    a_clk_wake: assert property (!clk_gate_o.sys_clk_en && !int_n_i |=> clk_gate_o.sys_clk_en)
        else $error("clock not restarted");
    a_div_ext: assert property (clk_div_one_o |-> !ext_clk_i)
        else $error("bypass with external clock");
    a_pin_reset: assert property (s_pin_low |-> ##[0:1] cpu_reset_o)
        else $error("pin reset ignored");
    a_fetch_zero: assert property ($fell(cpu_reset_o) |-> fetch_start_o && fetch_addr_o == RESET_VECTOR)
        else $error("fetch not from zero");
endmodule // scd_monitor

// ### sim/scd_core_model.sv
// Behavioural core bus model issuing memory cycles to the block
`timescale 1ns/100ps
module scd_core_model
    import scd_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Request from the bench
    input wire logic go_i,
    input wire logic [15:0] addr_i,
    input wire logic wr_i,
    input wire logic opc_i,
    // Block side
    input wire scd_mem_strobe_t strb_i,
    output scd_mem_cycle_t cyc_o,
    // Observations
    output logic busy_o,
    output scd_mem_strobe_t first_o,
    output scd_mem_strobe_t second_o,
    output logic [2:0] waits_o
);
    integer ph;
    // Address first, data a cycle later, hold through waits, then release
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cyc_o <= '0;
            busy_o <= 0;
            ph <= 0;
            waits_o <= 0;
        end else if (go_i && !busy_o) begin
            cyc_o <= {1'b1, opc_i, wr_i, 1'b1, 1'b0, addr_i};
            busy_o <= 1;
            ph <= 0;
            waits_o <= 0;
        end else if (busy_o) begin
            ph <= ph + 1;
            if (ph == 0) cyc_o.data_stable <= cyc_o.write;
            if (ph == 1) first_o <= strb_i;
            if (ph == 2) second_o <= strb_i;
            if (ph > 0 && !strb_i.wait_n) waits_o <= waits_o + 3'h1;
            if (ph > 1 && strb_i.wait_n) begin
                cyc_o <= {5'h00, ~cyc_o.addr}; // Released bus shows the inverse
                busy_o <= 0;
            end
        end
    end
endmodule // scd_core_model

// ### sim/tb.sv
// Self-checking bench for the system control block
`timescale 1ns/100ps
module tb;
    import scd_pkg::*;
    // ==========
    // Signals
    logic clk_i = 0, rst_i = 1, io_wr_i = 0, io_rd_i = 0, io_ack_o;
    logic [7:0] io_addr_i = 0, io_wdata_i = 0, io_rdata_o;
    logic halt_t4_i = 0, reset_n_i = 1, nmi_n_i = 1, int_n_i = 1, iff_i = 1, ext_clk_i = 0;
    logic halt_release_o, int_accept_o, iff_set_o, cpu_reset_o, fetch_start_o, clk_div_one_o, wd_run_o;
    logic [15:0] fetch_addr_o, addr = 0;
    logic [1:0] wd_period_o;
    scd_mem_cycle_t mem_cyc_i;
    scd_mem_strobe_t mem_strb_o, strb_a, strb_b;
    scd_clk_gate_t clk_gate_o;
    logic go = 0, wr = 0, opc = 0, busy;
    logic [2:0] waits;
    logic [7:0] cr [4] = '{8'h00, 8'hF0, 8'h0F, 8'h01}; // Bench copy of indirect registers
    integer errors = 0, total_checks = 0, seed = 3, cycles = 0, k, m, i;
    // ==========
    // Clock, timeout and instances
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            end_sim;
        end
    end
    scd_top i_dut (.clk_i, .rst_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o, .io_ack_o,
        .mem_cyc_i, .mem_strb_o, .halt_t4_i, .reset_n_i, .nmi_n_i, .int_n_i, .iff_i, .ext_clk_i,
        .halt_release_o, .int_accept_o, .iff_set_o, .cpu_reset_o, .fetch_start_o, .fetch_addr_o,
        .clk_gate_o, .clk_div_one_o, .wd_run_o, .wd_period_o);
    scd_core_model i_core (.clk_i, .rst_i, .go_i(go), .addr_i(addr), .wr_i(wr), .opc_i(opc),
        .strb_i(mem_strb_o), .cyc_o(mem_cyc_i), .busy_o(busy), .first_o(strb_a), .second_o(strb_b),
        .waits_o(waits));
    // ==========
    // Tasks
    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task io(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        io_wr_i = w;
        io_rd_i = !w;
        io_addr_i = a;
        io_wdata_i = d;
        @(posedge clk_i);
        #1;
        io_wr_i = 0;
        io_rd_i = 0;
        chk(io_ack_o, 1);
    endtask
    task cw(input integer x, input logic [7:0] v);
        io(1, CTRL_INDEX_ADDR, x[7:0]);
        io(1, CTRL_VALUE_ADDR, v);
        cr[x] = (x == 3) ? (v & MISC_RSVD_MASK) : v;
    endtask
    task crd(input integer x);
        io(1, CTRL_INDEX_ADDR, x[7:0]);
        io(0, CTRL_VALUE_ADDR, 8'h00);
        chk(io_rdata_o, cr[x]);
    endtask
    task mem(input logic [15:0] a, input logic w, input logic o);
        integer j;
        @(posedge clk_i);
        #1;
        {addr, wr, opc, go} = {a, w, o, 1'b1};
        @(posedge clk_i);
        #1;
        go = 0;
        for (j = 0; busy === 1 && j < 40; j++) @(posedge clk_i) #1;
        j = a[15:12];
        chk(waits, (cr[1][7:4] >= j && j >= cr[1][3:0]) ? cr[0][1:0] + (o & cr[0][2]) : 0);
        chk({strb_a.memory_request_strobe_n, strb_a.wr_n, strb_b.wr_n}, {2'b01, !w});
        chk(strb_a.low_sel_n, !(cr[3][0] && j <= cr[2][3:0]));
        chk(strb_a.upper_sel_n, !(cr[3][1] && j > cr[2][3:0] && j <= cr[2][7:4]));
        @(posedge clk_i);
        #1;
        chk(mem_strb_o.low_sel_n & mem_strb_o.upper_sel_n, 1);
    endtask
    task end_sim;
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ==========
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        #1;
        rst_i = 0;
        for (i = 0; i < 4; i++) crd(i);
        cw(3, 8'h1F);
        crd(3);
        chk(clk_div_one_o, 1);
        ext_clk_i = 1;
        #1 chk(clk_div_one_o, 0);
        ext_clk_i = 0;
        // Watchdog keys
        io(1, WD_MASTER_ADDR, 8'hC0);
        chk({wd_run_o, wd_period_o}, 3'b110);
        io(1, WD_COMMAND_ADDR, WD_DISABLE_KEY);
        chk(wd_run_o, 1);
        io(1, WD_MASTER_ADDR, 8'h40);
        io(1, WD_COMMAND_ADDR, 8'h4E);
        chk(wd_run_o, 1);
        io(1, WD_COMMAND_ADDR, WD_DISABLE_KEY);
        chk(wd_run_o, 0);
        io(0, WD_COMMAND_ADDR, 8'h00);
        chk(io_rdata_o, 8'h00);
        io(0, 8'h55, 8'h00);
        chk(io_rdata_o, 8'h00);
        // Random decode configurations and accesses
        for (i = 0; i < 4; i++) begin
            cw(0, $random(seed));
            cw(1, $random(seed));
            cw(2, $random(seed));
            cw(3, $random(seed) & 8'h03);
            for (k = 0; k < 6; k++) mem($random(seed), $random(seed), $random(seed));
        end
        // Halt in each mode, woken by interrupt or nonmaskable interrupt
        for (m = 0; m < 4; m++) begin
            io(1, WD_MASTER_ADDR, 8'h80 | m << HALT_MODE_LSB);
            @(posedge clk_i) #1 halt_t4_i = 1;
            @(posedge clk_i) #1 halt_t4_i = 0;
            chk({clk_gate_o.sys_clk_en, clk_gate_o.timer_clk_en, clk_gate_o.clk_out_en, clk_gate_o.wd_clk_en,
                wd_run_o}, {m == 3, m == 3 || m == 1, m != 2, m != 2, m != 2});
            if (m[0]) nmi_n_i = 0;
            else int_n_i = 0;
            @(posedge clk_i) #1 chk(clk_gate_o.sys_clk_en, 1);
            if (!m[0]) begin
                iff_i = 0;
                halt_t4_i = 1;
                @(posedge clk_i) #1 chk(halt_release_o, 0);
                iff_i = 1;
            end
            halt_t4_i = 1;
            @(posedge clk_i) #1 halt_t4_i = 0;
            for (k = 0; halt_release_o !== 1 && k < 4; k++) @(posedge clk_i) #1;
            chk({halt_release_o, int_accept_o, iff_set_o}, {2'b11, !m[0]});
            nmi_n_i = 1;
            int_n_i = 1;
        end
        // Pin reset and restart fetch
        reset_n_i = 0;
        repeat (4) @(posedge clk_i);
        #1 chk(cpu_reset_o, 1);
        reset_n_i = 1;
        for (k = 0; fetch_start_o !== 1 && k < 10; k++) @(posedge clk_i) #1;
        chk({fetch_start_o, fetch_addr_o}, {1'b1, RESET_VECTOR});
        chk(k >= 2, 1);
        end_sim;
    end
endmodule // tb
bind scd_top scd_monitor #(.RESET_MIN(RESET_MIN), .DUMMY_MIN(DUMMY_MIN)) i_mon (.clk_i(clk_i), .rst_i(rst_i),
    .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_ack_o(io_ack_o),
    .mem_cyc_i(mem_cyc_i), .mem_strb_o(mem_strb_o), .reset_n_i(reset_n_i), .int_n_i(int_n_i),
    .ext_clk_i(ext_clk_i), .cpu_reset_o(cpu_reset_o), .fetch_start_o(fetch_start_o), .fetch_addr_o(fetch_addr_o),
    .clk_gate_o(clk_gate_o), .clk_div_one_o(clk_div_one_o), .wd_run_o(wd_run_o), .wd_period_o(wd_period_o));
